// File: mute_scene_controller.sv
// Mute scene controller: scenes, safe set, local mutes, panel and registers.
`include "mute_scene_map.svh"
`default_nettype none
// How it works
// - Stores 128 sequenced patterns and 8 manual patterns, each any channel set.
// - Up/down presses step displayed patch, holding repeats; utility steps settings.
// - Four-character display shows patch 1..128, or the setting in utility.
// - Edit-preview press toggles scene edit; its red LED blinks; mutes edit scene.
// - Edit-safe press toggles safe edit; its green LED blinks; mutes edit safe set.
// - Safe channels are never muted by scenes; stored patterns stay untouched.
// - Nine sources, any combination active; scene mute is their union.
// - With single-scene engaged only one of nine sources may be active.
// - Utility switch latches utility mode, using up/down and display for settings.
// - Sequenced-scene switch enables the active patch as a mute source.
// - Manual switches activate patterns; in scene edit they pick the edit target.
// - Recall press with displayed equal to active advances both active and displayed patch by one.
// - Asterisk shows when displayed differs from active; recall activates displayed.
// - Patch actions always update number; mutes apply only with sequence lit.
// - Status LED: off, red, green, blinking red or blinking green.
// - Normal mute press toggles local mute; edit modes assign channel instead.
// - Mute LED and mute output are local mute OR scene mute.
// - Local mute toggles even behind a scene mute while live edit is off, and shows once it ends.
// - Every power-up clears memory; up and down held there also preset patch 128 to mute all.
// - Live-edit option lets a mute press remove scene mute from active scenes.
// - Safe membership never affects local mute.
// - Scene edits take effect at once and are kept without a store step.
module mute_scene_controller
  import mute_scene_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int NUM_SEQ = 128,
  parameter int NUM_MAN = 8,
  parameter int DEB_CYC = `DEBOUNCE_MS * `CYC_PER_MS,
  parameter int REP_DLY_CYC = `REPEAT_DELAY_MS * `CYC_PER_MS,
  parameter int REP_RATE_CYC = `REPEAT_RATE_MS * `CYC_PER_MS,
  parameter int BLINK_CYC = `BLINK_HALF_MS * `CYC_PER_MS
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic up_sw_in,
  input wire logic down_sw_in,
  input wire logic recall_sw_in,
  input wire logic edit_preview_sw_in,
  input wire logic edit_safe_sw_in,
  input wire logic single_sw_in,
  input wire logic utility_sw_in,
  input wire logic seq_sw_in,
  input wire logic [NUM_MAN-1:0] manual_sw_in,
  input wire logic [NUM_CH-1:0] mute_sw_in,
  output logic [31:0] display_out,
  output logic edit_preview_led_out,
  output logic edit_safe_led_out,
  output logic single_led_out,
  output logic utility_led_out,
  output logic seq_led_out,
  output logic [NUM_MAN-1:0] manual_led_out,
  output logic [NUM_CH-1:0] status_red_out,
  output logic [NUM_CH-1:0] status_green_out,
  output logic [NUM_CH-1:0] mute_led_out,
  output logic [NUM_CH-1:0] mute_out
);
  localparam int PW = $clog2(NUM_SEQ);
  localparam int SW_W = `SW_MUTE_LSB + NUM_CH;
  localparam int NSRC = NUM_MAN + 1;
  localparam logic [PW-1:0] LAST_PATCH = PW'(NUM_SEQ - 1);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Three ASCII digits of a patch number counted from one.
  function automatic logic [23:0] digits3(input logic [PW-1:0] p);
    int n;
    n = int'(p) + 1;
    return {8'(8'h30 + n / 100), 8'(8'h30 + (n / 10) % 10),
            8'(8'h30 + n % 10)};
  endfunction

  // Index of the lowest active source, or the sequenced source if none.
  function automatic logic [3:0] first_src(input logic [NSRC-1:0] s);
    logic [3:0] idx;
    idx = 4'(`SRC_SEQ);
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (s[k]) begin
        idx = 4'(k);
      end
    end
    return idx;
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [NUM_CH-1:0] seq_mem [NUM_SEQ];
  logic [NUM_CH-1:0] man_pat_reg [NUM_MAN];
  logic [NUM_CH-1:0] local_reg, safe_reg, ctrl_mask_reg;
  logic [PW-1:0] active_reg, disp_reg, clr_addr_reg;
  logic [NSRC-1:0] src_reg;
  logic [3:0] edit_sel_reg;
  mode_t mode_reg;
  logic util_reg, live_edit_reg, busy_reg, factory_reg, strap_done_reg;
  logic single_prev_reg, blink_reg, rep_tick_reg;
  logic [31:0] blink_cnt_reg, rep_cnt_reg;
  logic [SW_W-1:0] sw_level, sw_press;
  logic [NUM_CH-1:0] scene_mute, edit_pat, m_press, m_live, m_loc;
  logic [NUM_CH-1:0] red_next, green_next;
  logic step_up, step_down, bus_req, bus_go;

  // --------------------------------------------------------------------
  // Switch conditioning
  // --------------------------------------------------------------------
  switch_debounce #(
    .WIDTH(SW_W),
    .SAMPLE_CYC(DEB_CYC)
  ) u_debounce (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in({mute_sw_in, manual_sw_in, seq_sw_in, utility_sw_in,
             single_sw_in, edit_safe_sw_in, edit_preview_sw_in,
             recall_sw_in, down_sw_in, up_sw_in}),
    .level_out(sw_level),
    .press_out(sw_press)
  );

  // Press events are dropped while memory is being swept after reset.
  assign step_up = !busy_reg && (sw_press[`SW_UP] ||
                   (rep_tick_reg && sw_level[`SW_UP]));
  assign step_down = !busy_reg && (sw_press[`SW_DOWN] ||
                     (rep_tick_reg && sw_level[`SW_DOWN]));
  assign m_press = busy_reg ? '0 : sw_press[`SW_MUTE_LSB +: NUM_CH];

  // Hold-to-scroll: first repeat after the delay, then at the repeat rate.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rep_cnt_reg <= '0;
      rep_tick_reg <= 1'b0;
    end else if (!(sw_level[`SW_UP] || sw_level[`SW_DOWN])) begin
      rep_cnt_reg <= '0;
      rep_tick_reg <= 1'b0;
    end else if (rep_cnt_reg == 32'(REP_DLY_CYC - 1)) begin
      rep_cnt_reg <= 32'(REP_DLY_CYC - REP_RATE_CYC);
      rep_tick_reg <= 1'b1;
    end else begin
      rep_cnt_reg <= rep_cnt_reg + 32'h0000_0001;
      rep_tick_reg <= 1'b0;
    end
  end

  // Blink timebase shared by the edit LEDs and the status LEDs.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYC - 1)) begin
      blink_cnt_reg <= '0;
      blink_reg <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------
  // Mute combination
  // --------------------------------------------------------------------
  // Safe only masks scene mutes; local mute passes untouched.
  always_comb begin
    scene_mute = src_reg[`SRC_SEQ] ? seq_mem[active_reg] : '0;
    for (int k = 0; k < NUM_MAN; k++) begin
      if (src_reg[k]) begin
        scene_mute = scene_mute | man_pat_reg[k];
      end
    end
    scene_mute = scene_mute & ~safe_reg & ctrl_mask_reg;
    edit_pat = (edit_sel_reg == 4'(`SRC_SEQ)) ? seq_mem[disp_reg] :
               man_pat_reg[edit_sel_reg[2:0]];
    m_live = (mode_reg == MODE_NORMAL && live_edit_reg) ?
             (m_press & scene_mute) : '0;
    m_loc = m_press & ~m_live;
  end

  // --------------------------------------------------------------------
  // Power-up strap and memory sweep
  // --------------------------------------------------------------------
  // The strap is caught on the first edge after release, not by the reset.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_done_reg <= 1'b0;
      factory_reg <= 1'b0;
      busy_reg <= 1'b1;
      clr_addr_reg <= '0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      factory_reg <= up_sw_in && down_sw_in;
    end else if (busy_reg) begin
      clr_addr_reg <= clr_addr_reg + 1'b1;
      busy_reg <= (clr_addr_reg != LAST_PATCH);
    end
  end

  // Sequenced pattern store; one write port for sweep, edit and live edit.
  always_ff @(posedge ref_clk_in) begin
    if (busy_reg && strap_done_reg) begin
      seq_mem[clr_addr_reg] <= (factory_reg && clr_addr_reg == LAST_PATCH) ?
                               '1 : '0;
    end else if (mode_reg == MODE_SCENE_EDIT &&
                 edit_sel_reg == 4'(`SRC_SEQ)) begin
      seq_mem[disp_reg] <= seq_mem[disp_reg] ^ m_press;
    end else if (src_reg[`SRC_SEQ]) begin
      seq_mem[active_reg] <= seq_mem[active_reg] & ~m_live;
    end
  end

  // Manual patterns live in flops so the sweep is not needed for them.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k < NUM_MAN; k++) begin
        man_pat_reg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_MAN; k++) begin
        if (mode_reg == MODE_SCENE_EDIT && edit_sel_reg == 4'(k)) begin
          man_pat_reg[k] <= man_pat_reg[k] ^ m_press;
        end else if (src_reg[k]) begin
          man_pat_reg[k] <= man_pat_reg[k] & ~m_live;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Modes, local mutes and the safe set
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= MODE_NORMAL;
      util_reg <= 1'b0;
    end else if (!busy_reg) begin
      if (sw_press[`SW_UTIL]) begin
        util_reg <= !util_reg;
      end
      case (mode_reg)
        MODE_NORMAL: begin
          if (sw_press[`SW_PREVIEW]) begin
            mode_reg <= MODE_SCENE_EDIT;
          end else if (sw_press[`SW_SAFE]) begin
            mode_reg <= MODE_SAFE_EDIT;
          end
        end
        MODE_SCENE_EDIT: begin
          if (sw_press[`SW_PREVIEW]) begin
            mode_reg <= MODE_NORMAL;
          end
        end
        MODE_SAFE_EDIT: begin
          if (sw_press[`SW_SAFE]) begin
            mode_reg <= MODE_NORMAL;
          end
        end
        default: begin
          mode_reg <= MODE_NORMAL;
        end
      endcase
    end
  end

  // Local mutes toggle even under a scene while live edit is off; safe membership never clears them.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      local_reg <= '0;
      safe_reg <= '0;
    end else if (mode_reg == MODE_NORMAL) begin
      local_reg <= local_reg ^ m_loc;
    end else if (mode_reg == MODE_SAFE_EDIT) begin
      safe_reg <= safe_reg ^ m_press;
    end
  end

  // --------------------------------------------------------------------
  // Patch numbers, sources and edit target
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_reg <= '0;
      disp_reg <= '0;
    end else if (mode_reg == MODE_SCENE_EDIT && sw_press[`SW_PREVIEW]) begin
      disp_reg <= active_reg;
    end else if (!util_reg && step_up) begin
      disp_reg <= (disp_reg == LAST_PATCH) ? '0 : disp_reg + 1'b1;
    end else if (!util_reg && step_down) begin
      disp_reg <= (disp_reg == '0) ? LAST_PATCH : disp_reg - 1'b1;
    end else if (!busy_reg && mode_reg == MODE_NORMAL &&
                 sw_press[`SW_RECALL]) begin
      if (disp_reg != active_reg) begin
        active_reg <= disp_reg;
      end else begin
        active_reg <= (active_reg == LAST_PATCH) ? '0 :
                      active_reg + 1'b1;
        disp_reg <= (active_reg == LAST_PATCH) ? '0 :
                    active_reg + 1'b1;
      end
    end
  end

  // Source presses toggle in normal mode and select a target in scene edit.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    logic [NSRC-1:0] p, t;
    if (!rst_n_in) begin
      src_reg <= '0;
      edit_sel_reg <= 4'(`SRC_SEQ);
      single_prev_reg <= 1'b0;
    end else begin
      p = busy_reg ? '0 : {sw_press[`SW_SEQ],
                           sw_press[`SW_MAN_LSB +: NUM_MAN]};
      t = src_reg;
      single_prev_reg <= sw_level[`SW_SINGLE];
      if (mode_reg == MODE_NORMAL && sw_press[`SW_PREVIEW]) begin
        edit_sel_reg <= (sw_level[`SW_SINGLE] && |src_reg) ?
                        first_src(src_reg) : 4'(`SRC_SEQ);
      end else if (mode_reg == MODE_SCENE_EDIT && |p) begin
        edit_sel_reg <= first_src(p);
      end
      if (mode_reg != MODE_SCENE_EDIT) begin
        t = src_reg ^ p;
      end
      if (sw_level[`SW_SINGLE]) begin
        if (|(p & ~src_reg) && mode_reg != MODE_SCENE_EDIT) begin
          t = p & ~src_reg;
        end
        t = t & (~t + 1'b1);
      end
      src_reg <= t;
    end
  end

  // --------------------------------------------------------------------
  // Configuration: live edit option and controlled channel mask
  // --------------------------------------------------------------------
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_go = avs_write_in && !avs_waitrequest_out;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      live_edit_reg <= 1'(`CTL_RESET);
      ctrl_mask_reg <= '1;
    end else if (bus_go && avs_address_in == `REG_CONTROL) begin
      live_edit_reg <= avs_writedata_in[`CTL_LIVE_EDIT_BIT];
    end else if (bus_go && avs_address_in == `REG_CTRL_MASK) begin
      ctrl_mask_reg <= avs_writedata_in[NUM_CH-1:0];
    end else if (util_reg && (step_up || step_down)) begin
      live_edit_reg <= !live_edit_reg;
    end
  end

  // One wait state: read data is loaded as waitrequest falls.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
    end else begin
      avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= '0;
        if (avs_address_in == `REG_STATUS) begin
          avs_readdata_out[`STAT_ACTIVE_LSB +: PW] <= active_reg;
          avs_readdata_out[`STAT_DISP_LSB +: PW] <= disp_reg;
          avs_readdata_out[`STAT_SRC_LSB +: NSRC] <= src_reg;
          avs_readdata_out[`STAT_MODE_LSB +: 3] <= mode_reg;
          avs_readdata_out[`STAT_UTIL_BIT] <= util_reg;
          avs_readdata_out[`STAT_BUSY_BIT] <= busy_reg;
          avs_readdata_out[`STAT_FACTORY_BIT] <= factory_reg;
        end else if (avs_address_in == `REG_CONTROL) begin
          avs_readdata_out[`CTL_LIVE_EDIT_BIT] <= live_edit_reg;
        end else if (avs_address_in == `REG_CTRL_MASK) begin
          avs_readdata_out[NUM_CH-1:0] <= ctrl_mask_reg;
        end else if (avs_address_in == `REG_MUTE) begin
          avs_readdata_out[NUM_CH-1:0] <= local_reg | scene_mute;
        end else if (avs_address_in == `REG_LOCAL) begin
          avs_readdata_out[NUM_CH-1:0] <= local_reg;
        end else if (avs_address_in == `REG_SAFE) begin
          avs_readdata_out[NUM_CH-1:0] <= safe_reg;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Indicators and mute outputs
  // --------------------------------------------------------------------
  always_comb begin
    red_next = '0;
    green_next = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ctrl_mask_reg[i]) begin
        case (mode_reg)
          MODE_SCENE_EDIT: red_next[i] = edit_pat[i] && blink_reg;
          MODE_SAFE_EDIT: green_next[i] = safe_reg[i] && blink_reg;
          default: begin
            green_next[i] = safe_reg[i];
            red_next[i] = !safe_reg[i] && scene_mute[i];
          end
        endcase
      end
    end
  end

  // All panel outputs are registered, so they lag their cause by one edge.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      display_out <= 32'h2020_2020;
      {edit_preview_led_out, edit_safe_led_out} <= 2'h0;
      {single_led_out, utility_led_out, seq_led_out} <= 3'h0;
      manual_led_out <= '0;
      status_red_out <= '0;
      status_green_out <= '0;
      mute_led_out <= '0;
      mute_out <= '0;
    end else begin
      if (util_reg) begin
        display_out <= {24'h45_4F_46, live_edit_reg ? 8'h31 : 8'h30};
      end else begin
        display_out <= {(disp_reg != active_reg) ? 8'h2A : 8'h20,
                        digits3(disp_reg)};
      end
      edit_preview_led_out <= (mode_reg == MODE_SCENE_EDIT) && blink_reg;
      edit_safe_led_out <= (mode_reg == MODE_SAFE_EDIT) && blink_reg;
      single_led_out <= sw_level[`SW_SINGLE];
      utility_led_out <= util_reg;
      if (mode_reg == MODE_SCENE_EDIT) begin
        seq_led_out <= (edit_sel_reg == 4'(`SRC_SEQ));
        for (int k = 0; k < NUM_MAN; k++) begin
          manual_led_out[k] <= (edit_sel_reg == 4'(k));
        end
      end else begin
        seq_led_out <= src_reg[`SRC_SEQ];
        manual_led_out <= src_reg[NUM_MAN-1:0];
      end
      status_red_out <= red_next;
      status_green_out <= green_next;
      mute_led_out <= local_reg | scene_mute;
      mute_out <= local_reg | scene_mute;
    end
  end
endmodule // mute_scene_controller
`default_nettype wire

// File: mute_scene_map.svh
// Register indices, field positions, reset values and timing for the mutes.
`ifndef MUTE_SCENE_MAP_SVH
`define MUTE_SCENE_MAP_SVH
// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define REG_STATUS 3'h0
`define REG_CONTROL 3'h1
`define REG_CTRL_MASK 3'h2
`define REG_MUTE 3'h3
`define REG_LOCAL 3'h4
`define REG_SAFE 3'h5
// ----------------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------------
`define STAT_ACTIVE_LSB 0
`define STAT_DISP_LSB 8
`define STAT_SRC_LSB 16
`define STAT_MODE_LSB 25
`define STAT_UTIL_BIT 28
`define STAT_BUSY_BIT 29
`define STAT_FACTORY_BIT 30
`define CTL_LIVE_EDIT_BIT 0
`define CTL_RESET 32'h0000_0000
// ----------------------------------------------------------------------
// Switch vector layout inside the debouncer
// ----------------------------------------------------------------------
`define SW_UP 0
`define SW_DOWN 1
`define SW_RECALL 2
`define SW_PREVIEW 3
`define SW_SAFE 4
`define SW_SINGLE 5
`define SW_UTIL 6
`define SW_SEQ 7
`define SW_MAN_LSB 8
`define SW_MUTE_LSB 16
`define SRC_SEQ 8
// ----------------------------------------------------------------------
// Timing, in milliseconds, and the clock rate
// ----------------------------------------------------------------------
`define CYC_PER_MS 10000
`define DEBOUNCE_MS 10
`define REPEAT_DELAY_MS 500
`define REPEAT_RATE_MS 100
`define BLINK_HALF_MS 250
`endif

// File: mute_scene_pkg.sv
// Types shared by the mute scene controller.
`default_nettype none
package mute_scene_pkg;
  // Operating mode of the controller, one-hot.
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SCENE_EDIT = 3'b010,
    MODE_SAFE_EDIT = 3'b100
  } mode_t;
endpackage
`default_nettype wire

// File: switch_debounce.sv
// Shared-tick debouncer with one-cycle press pulses for a switch vector.
`default_nettype none
module switch_debounce #(
  parameter int WIDTH = 1,
  parameter int SAMPLE_CYC = 100000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] press_out
);
  localparam int CNT_W = $clog2(SAMPLE_CYC + 1);
  logic [CNT_W-1:0] tick_cnt_reg;
  logic tick;
  logic [WIDTH-1:0] sample_reg;
  logic [WIDTH-1:0] prev_reg;

  assign tick = (tick_cnt_reg == CNT_W'(SAMPLE_CYC - 1));

  // One counter serves every bit; cheaper than a counter per switch.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // A level changes only after two equal samples one tick apart.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_reg <= '0;
      level_out <= '0;
    end else if (tick) begin
      sample_reg <= raw_in;
      level_out <= (raw_in & sample_reg) | (level_out & (raw_in | sample_reg));
    end
  end

  // Rising edge of the clean level gives exactly one pulse per press.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= '0;
      press_out <= '0;
    end else begin
      prev_reg <= level_out;
      press_out <= level_out & ~prev_reg;
    end
  end
endmodule // switch_debounce
`default_nettype wire

// File: front_panel_model.sv
// Front-panel switch contacts that follow the operator's hands.
`default_nettype none
module front_panel_model (
  input wire logic clk_in,
  input wire logic [23:0] hand_in,
  output logic [23:0] sw_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts close one edge after the hand moves, so no pin changes on
  // the edge at which the design samples it.
  always @(posedge clk_in) sw_out <= hand_in;
endmodule // front_panel_model
`default_nettype wire

// File: mute_scene_controller_asserts.sv
// Port checks for the mute scene controller.
`default_nettype none
module mute_scene_controller_asserts #(
  parameter int NUM_CH = 8,
  parameter int NUM_MAN = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic [31:0] display_out,
  input wire logic edit_preview_led_out,
  input wire logic edit_safe_led_out,
  input wire logic single_led_out,
  input wire logic utility_led_out,
  input wire logic seq_led_out,
  input wire logic [NUM_MAN-1:0] manual_led_out,
  input wire logic [NUM_CH-1:0] status_red_out,
  input wire logic [NUM_CH-1:0] status_green_out,
  input wire logic [NUM_CH-1:0] mute_led_out,
  input wire logic [NUM_CH-1:0] mute_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Normal display only; the utility text and the reset blank are skipped.
  sequence s_norm;
    !utility_led_out && !$past(utility_led_out) && display_out != "    ";
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_ack; $rose(avs_read_in || avs_write_in) |=> s_ans; endproperty
  property p_mute; mute_led_out == mute_out; endproperty
  property p_bicol; (status_red_out & status_green_out) == '0; endproperty
  property p_single; single_led_out && $past(single_led_out, 2)
    |-> $onehot0({seq_led_out, manual_led_out}); endproperty
  property p_star; s_norm |-> display_out[31:24] inside {8'h20, 8'h2A};
  endproperty
  property p_hund; s_norm |-> display_out[23:16] inside {8'h30, 8'h31};
  endproperty
  property p_util; utility_led_out && $past(utility_led_out)
    |-> display_out[31:8] == 24'h454F46; endproperty
  property p_excl; !(edit_preview_led_out && edit_safe_led_out); endproperty
  property p_red; !edit_preview_led_out
    |-> (status_red_out & ~mute_led_out) == '0; endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  a_mute: assert property (p_mute) else $error("mute led");
  a_bicol: assert property (p_bicol) else $error("status led");
  a_single: assert property (p_single) else $error("single");
  a_star: assert property (p_star) else $error("first char");
  a_hund: assert property (p_hund) else $error("patch range");
  a_util: assert property (p_util) else $error("utility text");
  a_excl: assert property (p_excl) else $error("two edit modes");
  a_red: assert property (p_red) else $error("red without mute");
endmodule // mute_scene_controller_asserts
bind mute_scene_controller mute_scene_controller_asserts
  #(.NUM_CH(NUM_CH), .NUM_MAN(NUM_MAN)) u_chk (.*);
`default_nettype wire

// File: testbench.sv
// Bench: panel presses and bus accesses against expected values.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, d, disp;
  logic wt, seq;
  logic [23:0] sw;
  // Both steppers are released at power-up, so no factory preset of patch 128 is asked.
  logic [23:0] hand = 24'h0;
  logic [7:0] man, grn, mute;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  // Free-running 10 MHz clock.
  initial forever #50 ref_clk_in = ~ref_clk_in;
  front_panel_model panel (.clk_in(ref_clk_in), .hand_in(hand), .sw_out(sw));
  mute_scene_controller #(.DEB_CYC(4), .REP_DLY_CYC(40),
    .REP_RATE_CYC(10), .BLINK_CYC(8)) DUT (.ref_clk_in, .rst_n_in,
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .up_sw_in(sw[0]), .down_sw_in(sw[1]),
    .recall_sw_in(sw[2]), .edit_preview_sw_in(sw[3]),
    .edit_safe_sw_in(sw[4]), .single_sw_in(sw[5]),
    .utility_sw_in(sw[6]), .seq_sw_in(sw[7]), .manual_sw_in(sw[15:8]),
    .mute_sw_in(sw[23:16]), .display_out(disp),
    .edit_preview_led_out(), .edit_safe_led_out(), .single_led_out(),
    .utility_led_out(), .seq_led_out(seq), .manual_led_out(man),
    .status_red_out(), .status_green_out(grn), .mute_led_out(),
    .mute_out(mute));
  // Held past two debounce ticks but short of the repeat delay.
  task automatic press(input int i);
    @(posedge ref_clk_in) hand[i] <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    hand[i] <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
  endtask
  // A level switch such as single scene stays engaged.
  task automatic hold(input int i);
    @(posedge ref_clk_in) hand[i] <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge; read
  // data is taken at that edge and the request dropped right after it.
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= v;
    do @(posedge ref_clk_in); while (wt !== 1'b0);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang is cut short well past the expected run length.
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      final_report();
    end
  end
  // Reset for 20 cycles, wait out the sweep, then run the tests.
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    d = 32'h2000_0000;
    while (d[29] !== 1'b0) bus(1'b0, 3'h0, 32'h0);
    chk(disp, " 001");
    bus(1'b0, 3'h2, 32'h0);
    chk(32'(d[7:0]), 32'hFF);
    bus(1'b0, 3'h6, 32'h0);
    chk(d, 32'h0);
    bus(1'b1, 3'h1, 32'h1);
    press(6);
    chk(disp, "EOF1");
    press(0);
    chk(disp, "EOF0");
    press(6);
    bus(1'b0, 3'h1, 32'h0);
    chk(d, 32'h0);
    $display("bus and utility test done");
    press(0);
    chk(disp, "*002");
    press(2);
    chk(disp, " 002");
    press(2);
    chk(disp, " 003");
    repeat (3) press(1);
    chk(disp, "*128");
    press(2);
    $display("patch test done");
    press(16);
    chk(32'(mute), 32'h1);
    press(3);
    press(17);
    press(3);
    chk(32'(mute), 32'h1);
    press(7);
    chk(32'(mute), 32'h3);
    press(16);
    chk(32'(mute), 32'h2);
    bus(1'b1, 3'h1, 32'h1);
    press(17);
    chk(32'(mute), 32'h0);
    press(3);
    press(17);
    press(3);
    chk(32'(mute), 32'h2);
    press(4);
    press(17);
    press(4);
    chk(32'(mute), 32'h0);
    chk(32'(grn), 32'h2);
    bus(1'b0, 3'h5, 32'h0);
    chk(d, 32'h2);
    press(8);
    chk(32'({seq, man}), 32'h101);
    hold(5);
    chk(32'({seq, man}), 32'h1);
    $display("scene test done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
